// File: logic/cds_cfg.svh
// constants for the clock divider and sleep control block
`ifndef CDS_CFG_SVH
`define CDS_CFG_SVH

// divider select codes and write sequence
`define CDS_SEL_NODIV      4'h0
`define CDS_SEL_DIV8       4'h3
`define CDS_SEL_MAX        4'h8
`define CDS_UNLOCK_BIT     7
`define CDS_UNLOCK_WORD    8'h80
`define CDS_UNLOCK_CYC     3'h4
`define CDS_SEL_LSB        0
`define CDS_SEL_MSB        3
`define CDS_FUSE_SYNC      2'h3

// low power mode select codes
`define CDS_MODE_IDLE      3'h0
`define CDS_MODE_NOISE     3'h1
`define CDS_MODE_PDOWN     3'h2
`define CDS_MODE_PSAVE     3'h3
`define CDS_MODE_STBY      3'h6
`define CDS_MODE_XSTBY     3'h7

// wake timing in cycles
`define CDS_HALT_EXTRA     16'h0004
`define CDS_STANDBY_START  16'h0006
`define CDS_STARTUP_DEF    6

`endif

// File: logic/cds_pkg.sv
// types shared by the clock divider and sleep control block
package cds_pkg;

	typedef enum logic [1:0] {
		CDS_RUN,
		CDS_SLEEP,
		CDS_WAKE
	} cds_state_t;

	// clock domain and oscillator enables, one bit each
	typedef struct packed {
		logic core_clock;
		logic program_memory_clock;
		logic peripheral_clock;
		logic converter_clock;
		logic async_timer_clock;
		logic main_osc;
		logic timer_osc;
	} cds_clk_t;

	// wake requests from the interrupt logic
	typedef struct packed {
		logic [7:0] external_interrupt_lines;
		logic       pin_change;
		logic       two_wire_interface;
		logic       watchdog_timer;
		logic       timer2;
		logic       self_program_store;
		logic       converter_done;
		logic       other_io;
	} cds_wake_t;

endpackage : cds_pkg

// File: logic/cds_div.sv
// glitch-free power-of-two divider of the master clock
`timescale 1ns/1ps
`default_nettype none
`include "cds_cfg.svh"
module cds_div
	import cds_pkg::*;
#(
	parameter int SEL_W = 4
) (
	input  wire logic             clock,    // master clock
	input  wire logic             nrst,     // async reset, low
	input  wire logic [SEL_W-1:0] sel,      // requested select code
	output logic                  tick,     // one divided clock edge
	output logic      [SEL_W-1:0] cur_sel   // select now in effect
);
	logic [7:0] cnt;
	logic [7:0] mask;

	generate
		if (SEL_W != 4) begin : g_bad_w
			$error("cds_div supports only a four bit select");
		end
	endgenerate

	// divide by two to the power of the code
	assign mask = 8'((9'h001 << cur_sel) - 9'h001);
	assign tick = ((cnt & mask) == mask);

	// the new factor is taken only at a period boundary, so no
	// intermediate period is shorter than either setting
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cnt     <= 8'h00;
			cur_sel <= `CDS_SEL_DIV8;
		end else if (tick) begin
			cnt     <= 8'h00;
			cur_sel <= sel;
		end else begin
			cnt     <= cnt + 8'h01;
		end
	end

	// code three gives one edge every eight cycles
	div_by8_a: assert property (@(posedge clock) disable iff (!nrst)
		(tick ##1 cur_sel == `CDS_SEL_DIV8) |-> (!tick)[*7] ##1 tick)
		else $error("divide by eight period wrong");

endmodule : cds_div
`default_nettype wire

// File: logic/cds_ctl.sv
// clock divider select and sleep mode control
//
// Operation
// - fuse unprogrammed: divider select resets to 0000, undivided clock; here it holds 0011 in reset until the synced fuse loads 0000.
// - fuse programmed: divider select resets to 0011, divide by eight.
// - any select value may be written whatever the fuse says; codes above 1000 are ignored and leave the select alone.
// - code n divides by two to the n up to 1000; above is reserved.
// - the start fuse is programmed as delivered.
// - sleep needs the sleep enable bit set plus a halt instruction.
// - the three bit mode select picks the sleep mode.
// - idle stops only core and program memory clocks.
// - each sleep mode keeps its own set of clocks and oscillators.
// - each sleep mode accepts its own set of wake sources.
// - timer oscillator, async clock, and timer 2 wake outside idle need async timer 2.
// - outside idle, lines 7 to 4 wake only as level interrupts.
// - after wake, halt four cycles plus start-up, then resume.
// - wake leaves register file and static memory unchanged.
// - reset while asleep wakes and restarts at the reset vector.
// - codes 001,010,011,110,111 select the other five modes.
// - standby and extended standby resume after six cycles start-up.
// - select write counts only within four cycles of an unlock write.
`timescale 1ns/1ps
`default_nettype none
`include "cds_cfg.svh"
module cds_ctl
	import cds_pkg::*;
#(
	parameter int   STARTUP_CYCLES = `CDS_STARTUP_DEF,
	parameter logic FUSE_DELIVERED = 1'b1
) (
	input  wire logic       clock,                      // master clock
	input  wire logic       nrst,                       // async reset, low
	input  wire logic       start_divide_by_eight_fuse, // 1 = programmed
	input  wire logic       prescale_wr,                // prescale write
	input  wire logic [7:0] prescale_wdata,             // prescale data
	input  wire logic       sleep_enable_bit,           // sleep allowed
	input  wire logic [2:0] low_power_mode_select,      // sleep mode code
	input  wire logic       halt_exec,                  // halt executed
	input  wire logic       timer2_async,               // timer 2 async
	input  wire logic [3:0] ext_int_level,              // lines 7:4 level
	input  wire cds_wake_t  wake_req,                   // wake requests
	output logic      [3:0] clock_divider_select,       // select register
	output logic            divider_change_unlock,      // unlock open
	output logic            sys_tick,                   // divided edge
	output cds_clk_t        clk_gate,                   // clock enables
	output logic            core_halted,                // core stopped
	output logic            resume_pulse                // resume after halt
);
	cds_state_t  state;
	cds_state_t  next_state;
	logic        fuse_s1;
	logic        fuse_s2;
	logic  [1:0] init_cnt;
	logic        loaded;
	logic  [2:0] unlock_cnt;
	logic  [2:0] mode;
	logic [15:0] wake_cnt;
	logic        wake_hit;
	logic        mode_ok;
	logic        sel_wr;
	cds_wake_t   wake_mask;
	cds_clk_t    next_gate;
	logic [15:0] exp_len;
	logic [15:0] wake_len;

	generate
		if (STARTUP_CYCLES < 1 || STARTUP_CYCLES > 65000) begin : g_bad
			$error("STARTUP_CYCLES out of range");
		end
	endgenerate

	// fuse is a pin level: two stages before use
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			fuse_s1 <= 1'b0;
			fuse_s2 <= 1'b0;
		end else begin
			fuse_s1 <= start_divide_by_eight_fuse;
			fuse_s2 <= fuse_s1;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			init_cnt <= 2'h0;
		end else if (init_cnt != `CDS_FUSE_SYNC) begin
			init_cnt <= init_cnt + 2'h1;
		end
	end
	assign loaded = (init_cnt == `CDS_FUSE_SYNC);

	// unlock only on the exact unlock word, not retriggerable
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			unlock_cnt <= 3'h0;
		end else if (sel_wr) begin
			unlock_cnt <= 3'h0;
		end else if (prescale_wr && loaded && unlock_cnt == 3'h0 &&
			prescale_wdata == `CDS_UNLOCK_WORD) begin
			unlock_cnt <= `CDS_UNLOCK_CYC;
		end else if (unlock_cnt != 3'h0) begin
			unlock_cnt <= unlock_cnt - 3'h1;
		end
	end
	assign divider_change_unlock = (unlock_cnt != 3'h0);
	assign sel_wr = prescale_wr && divider_change_unlock &&
		!prescale_wdata[`CDS_UNLOCK_BIT];

	// the reset value is the delivered fuse state until the synced
	// fuse can be sampled, since a pin may not feed a reset value
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			clock_divider_select <= FUSE_DELIVERED ? `CDS_SEL_DIV8 :
				`CDS_SEL_NODIV;
		end else if (init_cnt == 2'h2) begin
			// fuse picks the start factor, read past both stages
			clock_divider_select <= fuse_s2 ? `CDS_SEL_DIV8 :
				`CDS_SEL_NODIV;
		end else if (sel_wr &&
			// reserved codes leave the factor alone
			prescale_wdata[`CDS_SEL_MSB:`CDS_SEL_LSB] <= `CDS_SEL_MAX) begin
			// fuse plays no part in a write
			clock_divider_select <= prescale_wdata[`CDS_SEL_MSB:`CDS_SEL_LSB];
		end
	end

	cds_div #(
		.SEL_W (4)
	) u_div (
		.clock   (clock),
		.nrst    (nrst),
		.sel     (clock_divider_select),
		.tick    (sys_tick),
		.cur_sel ()
	);

	// only the six defined codes enter sleep
	always_comb begin
		case (low_power_mode_select)
			`CDS_MODE_IDLE, `CDS_MODE_NOISE, `CDS_MODE_PDOWN,
			`CDS_MODE_PSAVE, `CDS_MODE_STBY, `CDS_MODE_XSTBY: mode_ok = 1'b1;
			default: mode_ok = 1'b0;
		endcase
	end

	always_comb begin
		wake_mask = '0;
		wake_mask.external_interrupt_lines = {ext_int_level, 4'hf};
		wake_mask.pin_change = 1'b1;
		wake_mask.two_wire_interface = 1'b1;
		wake_mask.watchdog_timer = 1'b1;
		case (mode)
			`CDS_MODE_IDLE: begin
				wake_mask = '1;
			end
			`CDS_MODE_NOISE: begin
				wake_mask.timer2 = timer2_async;
				wake_mask.self_program_store = 1'b1;
				wake_mask.converter_done = 1'b1;
			end
			`CDS_MODE_PSAVE, `CDS_MODE_XSTBY: begin
				wake_mask.timer2 = timer2_async;
			end
			default: begin
			end
		endcase
	end
	assign wake_hit = |(wake_req & wake_mask);

	// halt four cycles plus the mode's start-up time
	always_comb begin
		case (mode)
			`CDS_MODE_STBY, `CDS_MODE_XSTBY:
				exp_len = `CDS_HALT_EXTRA + `CDS_STANDBY_START;
			`CDS_MODE_PDOWN, `CDS_MODE_PSAVE:
				exp_len = `CDS_HALT_EXTRA + 16'(STARTUP_CYCLES);
			default:
				exp_len = `CDS_HALT_EXTRA;
		endcase
	end

	always_comb begin
		next_state = state;
		case (state)
			CDS_RUN: begin
				// sleep enable plus halt with a defined mode code, otherwise no-op
				if (halt_exec && sleep_enable_bit && mode_ok)
					next_state = CDS_SLEEP;
			end
			CDS_SLEEP: begin
				if (wake_hit)
					next_state = CDS_WAKE;
			end
			CDS_WAKE: begin
				if (wake_cnt == 16'h0000)
					next_state = CDS_RUN;
			end
			default: next_state = CDS_RUN;
		endcase
	end

	// reset in any state returns to run from the reset vector
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			state <= CDS_RUN;
		else
			state <= next_state;
	end

	// mode is frozen for the whole sleep
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			mode <= `CDS_MODE_IDLE;
		else if (state == CDS_RUN)
			mode <= low_power_mode_select;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			wake_cnt <= 16'h0000;
		else if (state == CDS_SLEEP)
			wake_cnt <= exp_len - 16'h0001;
		else if (wake_cnt != 16'h0000)
			wake_cnt <= wake_cnt - 16'h0001;
	end

	// clock enables follow the next state
	always_comb begin
		next_gate = '0;
		next_gate.async_timer_clock = timer2_async;
		next_gate.timer_osc = timer2_async;
		case (next_state)
			CDS_RUN: begin
				next_gate = '1;
				next_gate.async_timer_clock = timer2_async;
				next_gate.timer_osc = timer2_async;
			end
			CDS_WAKE: begin
				next_gate.peripheral_clock = 1'b1;
				next_gate.converter_clock = 1'b1;
				next_gate.main_osc = 1'b1;
			end
			default: begin
				// while asleep the frozen mode rules, not the live input
				case ((state == CDS_RUN) ? low_power_mode_select : mode)
					`CDS_MODE_IDLE: begin
						next_gate.peripheral_clock = 1'b1;
						next_gate.converter_clock = 1'b1;
						next_gate.main_osc = 1'b1;
					end
					`CDS_MODE_NOISE: begin
						next_gate.converter_clock = 1'b1;
						next_gate.main_osc = 1'b1;
					end
					`CDS_MODE_STBY: begin
						next_gate.main_osc = 1'b1;
						next_gate.async_timer_clock = 1'b0;
						next_gate.timer_osc = 1'b0;
					end
					`CDS_MODE_XSTBY: begin
						next_gate.main_osc = 1'b1;
					end
					`CDS_MODE_PSAVE: begin
					end
					default: begin
						next_gate.async_timer_clock = 1'b0;
						next_gate.timer_osc = 1'b0;
					end
				endcase
			end
		endcase
	end

	// only clocks are gated, stored contents are never touched
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			clk_gate <= '1;
		else
			clk_gate <= next_gate;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			resume_pulse <= 1'b0;
		else
			resume_pulse <= (state == CDS_WAKE) && (next_state == CDS_RUN);
	end
	assign core_halted = (state != CDS_RUN);

	// helper: cycles spent halted after a wake
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			wake_len <= 16'h0000;
		else if (state == CDS_WAKE)
			wake_len <= wake_len + 16'h0001;
		else
			wake_len <= 16'h0000;
	end

	sequence s_enter;
		state == CDS_RUN && halt_exec && sleep_enable_bit && mode_ok;
	endsequence
	sequence s_wake;
		state == CDS_SLEEP && wake_hit;
	endsequence

	sel_reset_a: assert property (@(posedge clock) disable iff (!nrst)
		(init_cnt == 2'h2 && !fuse_s2) |=> clock_divider_select == 4'h0)
		else $error("select not 0000 after reset with fuse clear");
	sel_div8_a: assert property (@(posedge clock) disable iff (!nrst)
		(init_cnt == 2'h2 && fuse_s2) |=> clock_divider_select == 4'h3)
		else $error("select not 0011 after reset with fuse set");
	sel_guard_a: assert property (@(posedge clock) disable iff (!nrst)
		(loaded && $past(loaded) && $changed(clock_divider_select)) |->
		$past(divider_change_unlock) && $past(prescale_wr))
		else $error("select changed outside unlock window");
	unlock_len_a: assert property (@(posedge clock) disable iff (!nrst)
		($rose(divider_change_unlock) && !prescale_wr) ##1 !prescale_wr
		##1 !prescale_wr ##1 !prescale_wr |=> !divider_change_unlock)
		else $error("unlock window not four cycles");
	sel_valid_a: assert property (@(posedge clock) disable iff (!nrst)
		clock_divider_select <= `CDS_SEL_MAX)
		else $error("reserved select code taken");
	halt_noop_a: assert property (@(posedge clock) disable iff (!nrst)
		(state == CDS_RUN && halt_exec && !sleep_enable_bit) |=>
		state == CDS_RUN && clk_gate.core_clock)
		else $error("halt without sleep enable stopped the core");
	sleep_entry_a: assert property (@(posedge clock) disable iff (!nrst)
		(state == CDS_RUN ##1 state == CDS_SLEEP) |->
		$past(halt_exec && sleep_enable_bit && mode_ok))
		else $error("sleep entered without enable and halt");
	sleep_taken_a: assert property (@(posedge clock) disable iff (!nrst)
		s_enter |=> core_halted && state == CDS_SLEEP)
		else $error("enable and halt did not enter sleep");
	wake_time_a: assert property (@(posedge clock) disable iff (!nrst)
		resume_pulse |-> $past(wake_len) == exp_len - 16'h0001)
		else $error("halt after wake has wrong length");
	standby_wake_a: assert property (@(posedge clock) disable iff (!nrst)
		(s_wake and (mode == `CDS_MODE_STBY)) |=>
		core_halted [*8] ##1 core_halted [*2] ##1 resume_pulse)
		else $error("standby wake not four plus six cycles");
	idle_clk_a: assert property (@(posedge clock) disable iff (!nrst)
		(state == CDS_SLEEP && mode == `CDS_MODE_IDLE) |->
		!clk_gate.core_clock && !clk_gate.program_memory_clock &&
		clk_gate.peripheral_clock && clk_gate.converter_clock)
		else $error("idle clock set wrong");
	pdown_clk_a: assert property (@(posedge clock) disable iff (!nrst)
		(state == CDS_SLEEP && mode == `CDS_MODE_PDOWN) |-> clk_gate == '0)
		else $error("power-down left a clock running");
	level_only_a: assert property (@(posedge clock) disable iff (!nrst)
		(state == CDS_SLEEP && mode != `CDS_MODE_IDLE &&
		(wake_req & {ext_int_level, 11'h7ff}) == '0 &&
		wake_req != '0) |=> state == CDS_SLEEP)
		else $error("edge interrupt on lines 7:4 woke the device");

endmodule : cds_ctl
`default_nettype wire

// File: verification/cds_core.sv
// behavioural model of the core issuing prescale writes and halts
`timescale 1ns/1ps
`default_nettype none
module cds_core (
	input  wire logic       clock,                 // master clock
	output logic            prescale_wr,           // prescale write strobe
	output logic      [7:0] prescale_wdata,        // prescale write data
	output logic            sleep_enable_bit,      // sleep allowed
	output logic      [2:0] low_power_mode_select, // sleep mode code
	output logic            halt_exec              // halt executed
);
	initial begin
		prescale_wr = 1'b0;
		prescale_wdata = 8'h5a;
		sleep_enable_bit = 1'b0;
		low_power_mode_select = 3'h0;
		halt_exec = 1'b0;
	end

	// data is not held after the strobe, so a late sample sees garbage
	task automatic strobe(input logic [7:0] d);
		@(negedge clock);
		prescale_wr = 1'b1;
		prescale_wdata = d;
		@(negedge clock);
		prescale_wr = 1'b0;
		prescale_wdata = ~d;
	endtask : strobe

	// unlock then select
	// gap above three idle cycles misses the window on purpose
	task automatic set_div(input logic [3:0] code, input int gap);
		@(negedge clock);
		prescale_wr = 1'b1;
		prescale_wdata = 8'h80;
		repeat (gap) begin
			@(negedge clock);
			prescale_wr = 1'b0;
			prescale_wdata = 8'h7f;
		end
		strobe({4'h0, code});
	endtask : set_div

	// crystal clock assumed whenever standby is requested
	task automatic halt(input logic se, input logic [2:0] mode);
		@(negedge clock);
		sleep_enable_bit = se;
		low_power_mode_select = mode;
		@(negedge clock);
		halt_exec = 1'b1;
		@(negedge clock);
		halt_exec = 1'b0;
	endtask : halt
endmodule : cds_core
`default_nettype wire

// File: verification/tb_cds_ctl.sv
// self-checking bench for the clock divider and sleep control block
`timescale 1ns/1ps
`default_nettype none
`include "cds_cfg.svh"
module tb_cds_ctl
	import cds_pkg::*;
;
	localparam cds_wake_t W_OTH = 15'h0001;
	localparam cds_wake_t W_CNV = 15'h0002;
	localparam cds_wake_t W_SPM = 15'h0004;
	localparam cds_wake_t W_TM2 = 15'h0008;
	localparam cds_wake_t W_WDT = 15'h0010;
	localparam cds_wake_t W_TWI = 15'h0020;
	localparam cds_wake_t W_PIN = 15'h0040;
	localparam cds_wake_t W_EX0 = 15'h0080;
	localparam cds_wake_t W_EX7 = 15'h4000;

	logic       clock;
	logic       nrst;
	logic       fuse;
	logic       t2_async;
	logic [3:0] ext_lvl;
	cds_wake_t  wake;
	logic       p_wr;
	logic [7:0] p_data;
	logic       se;
	logic [2:0] mode;
	logic       halt;
	logic [3:0] sel;
	logic       unlock;
	logic       tick;
	cds_clk_t   gate;
	logic [6:0] run_gate;
	logic       halted;
	logic       resume;
	int         num_errors;
	int         compares;

	always #4 clock = ~clock;

	// running: all on, async clock and timer oscillator only if timer 2 async
	assign run_gate = {4'hf, t2_async, 1'b1, t2_async};

	cds_core u_cds_core (.clock(clock), .prescale_wr(p_wr),
		.prescale_wdata(p_data), .sleep_enable_bit(se),
		.low_power_mode_select(mode), .halt_exec(halt));

	cds_ctl #(.STARTUP_CYCLES(3)) u_cds_ctl (.clock(clock), .nrst(nrst),
		.start_divide_by_eight_fuse(fuse), .prescale_wr(p_wr),
		.prescale_wdata(p_data), .sleep_enable_bit(se),
		.low_power_mode_select(mode), .halt_exec(halt),
		.timer2_async(t2_async), .ext_int_level(ext_lvl), .wake_req(wake),
		.clock_divider_select(sel), .divider_change_unlock(unlock),
		.sys_tick(tick), .clk_gate(gate), .core_halted(halted),
		.resume_pulse(resume));

	task automatic check_val(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check_val

	task automatic check_cnt(input string what, input int exp, input int got);
		compares++;
		if (got != exp) begin
			num_errors++;
			$display("wrong value %s expected %0d seen %0d", what, exp, got);
		end
	endtask : check_cnt

	task automatic end_of_test;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test

	task automatic do_reset(input logic f, input logic [3:0] exp);
		@(negedge clock);
		nrst = 1'b0;
		fuse = f;
		wake = '0;
		@(negedge clock);
		check_val("select in reset", 4'h3, sel);
		check_val("halted in reset", 1'b0, halted);
		check_val("gates in reset", 7'h7f, gate);
		repeat (4) @(negedge clock);
		nrst = 1'b1;
		repeat (3) @(negedge clock);
		check_val("select after reset", exp, sel);
	endtask : do_reset

	// the last of three tick gaps is surely at the adopted code
	task automatic div_case(input logic [3:0] code, input int gap,
		input logic [3:0] exp_sel, input int exp_per);
		int n;
		u_cds_core.set_div(code, gap);
		check_val("select", exp_sel, sel);
		check_val("unlock closed", 1'b0, unlock);
		repeat (3) begin
			n = 0;
			do begin
				@(negedge clock);
				n++;
			end while (tick !== 1'b1 && n < 600);
		end
		check_cnt("tick period", exp_per, n);
	endtask : div_case

	task automatic sleep_case(input logic [2:0] m, input logic [6:0] exp_gate,
		input cds_wake_t nowake, input cds_wake_t src, input int lat);
		int n;
		u_cds_core.halt(1'b1, m);
		check_val("halted", 1'b1, halted);
		check_val("sleep gates", exp_gate, gate);
		wake = nowake;
		repeat (4) @(negedge clock);
		check_val("halted no wake", 1'b1, halted);
		wake = src;
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (resume !== 1'b1 && n < 40);
		wake = '0;
		check_cnt("wake latency", lat + 1, n);
		check_val("halted after resume", 1'b0, halted);
		check_val("run gates", run_gate, gate);
	endtask : sleep_case

	task automatic halt_ignored(input logic s, input logic [2:0] m);
		u_cds_core.halt(s, m);
		repeat (2) begin
			check_val("halt ignored", 1'b0, halted);
			check_val("gates kept", run_gate, gate);
			@(negedge clock);
		end
	endtask : halt_ignored

	initial begin
		#100000;
		num_errors++;
		end_of_test();
	end

	initial begin
		clock = 1'b0;
		nrst = 1'b0;
		fuse = 1'b1;
		t2_async = 1'b1;
		ext_lvl = 4'h0;
		wake = '0;
		num_errors = 0;
		compares = 0;
		do_reset(1'b1, 4'h3);
		for (int c = 0; c <= 8; c++)
			div_case(c[3:0], c % 4, c[3:0], 1 << c);
		div_case(4'h2, 3, 4'h2, 4);
		div_case(4'h5, 4, 4'h2, 4);
		div_case(4'h9, 0, 4'h2, 4);
		do_reset(1'b0, 4'h0);
		div_case(4'h3, 1, 4'h3, 8);
		sleep_case(`CDS_MODE_IDLE, 7'h1f, '0, W_OTH, 4);
		sleep_case(`CDS_MODE_NOISE, 7'h0f, W_OTH, W_CNV, 4);
		sleep_case(`CDS_MODE_PDOWN, 7'h00, W_EX7, W_PIN, 7);
		sleep_case(`CDS_MODE_PSAVE, 7'h05, W_SPM, W_TM2, 7);
		sleep_case(`CDS_MODE_STBY, 7'h02, W_TM2, W_TWI, 10);
		sleep_case(`CDS_MODE_XSTBY, 7'h07, W_CNV, W_WDT, 10);
		ext_lvl = 4'h8;
		sleep_case(`CDS_MODE_PDOWN, 7'h00, W_OTH | W_TM2, W_EX7, 7);
		t2_async = 1'b0;
		sleep_case(`CDS_MODE_PSAVE, 7'h00, W_TM2, W_EX0, 7);
		halt_ignored(1'b0, `CDS_MODE_IDLE);
		halt_ignored(1'b1, 3'h4);
		halt_ignored(1'b1, 3'h5);
		u_cds_core.halt(1'b1, `CDS_MODE_PDOWN);
		check_val("asleep before reset", 1'b1, halted);
		do_reset(1'b1, 4'h3);
		check_val("run after reset", 1'b0, halted);
		end_of_test();
	end
endmodule : tb_cds_ctl
`default_nettype wire
